// [design/eip_cmp.sv]
// Two-input priority comparator of the evaluation tree
`timescale 1ns/1ps
`default_nettype none
module eip_cmp (
   input  wire eip_pkg::eip_cand_t a_in,
   input  wire eip_pkg::eip_cand_t b_in,
   output var  eip_pkg::eip_cand_t win_out
);
   import eip_pkg::*;

   // Left input always holds the lower IDs
   always_comb begin
      if (a_in.prio >= b_in.prio) begin
         win_out = a_in;
      end else begin
         win_out = b_in;
      end
   end

endmodule
`default_nettype wire

// [design/eip_gateway.sv]
// Per-source gateway: synchroniser, polarity, edge latch
`timescale 1ns/1ps
`default_nettype none
module eip_gateway (
   input  wire logic clk_sys_in,
   input  wire logic srst_in,
   input  wire logic src_in,
   input  wire logic pol_in,
   input  wire logic edge_in,
   input  wire logic clr_in,
   output logic      req_out
);
   import eip_pkg::*;

   eip_gw_state_t s;
   eip_gw_state_t next_s;
   logic          active;
   logic          was_active;

   // ----------------------------------------------------------------
   // Sync, edge latch
   // ----------------------------------------------------------------
   always_comb begin
      next_s      = s;
      next_s.meta = src_in;
      next_s.sync = s.meta;
      next_s.prev = s.sync;
      active      = s.sync ^ pol_in;
      was_active  = s.prev ^ pol_in;
      if (edge_in && active && !was_active) begin
         next_s.pend = 1'b1;
      end else if (clr_in) begin
         next_s.pend = 1'b0;
      end
      req_out = edge_in ? s.pend : active;
   end

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

endmodule
`default_nettype wire

// [design/eip_top.sv]
// External interrupt prioritizer: gateways, evaluation tree, registers
//
// Notes on behaviour
// - Gateways hold polarity and type; clear register write drops pending flop unless a new edge sets it in the same cycle.
// - Each request is synchronised into the controller clock before evaluation.
// - Edge sources set a pending flop held as level until cleared.
// - Every gateway request is readable in the pending bank.
// - Only pending and enabled sources feed their priority into the tree.
// - Comparators pass higher priority; on ties the lower source ID.
// - Hart request is set when winner exceeds max of threshold and level.
// - Hart request level is visible as the external pending bit.
// - Wake flag set when winner priority is top level; drives wake output.
// - The hart masks interrupts and enters the handler on taking it.
// - Capture write loads winner ID and priority together.
// - Capture ignores threshold, handler level and hart enable.
// - A cleared request leaves the winner selection.
// - Evaluation runs continuously; hart request follows remaining qualifiers.
// - Captured values change only on a further capture write.
// - Reverse order inverts priority fields on write and read.
// - Up to 255 sources, IDs from 1, fifteen priority levels.
//
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module eip_top #(
   parameter int unsigned NUM_SRC = 255
) (
   input  wire logic                          clk_sys_in,
   input  wire logic                          srst_in,
   input  wire logic [NUM_SRC:1]              src_req_in,
   input  wire logic [eip_pkg::ADDR_W-1:0]    avs_address_in,
   input  wire logic                          avs_read_in,
   input  wire logic                          avs_write_in,
   input  wire logic [eip_pkg::DATA_W-1:0]    avs_writedata_in,
   input  wire logic [3:0]                    avs_byteenable_in,
   output logic      [eip_pkg::DATA_W-1:0]    avs_readdata_out,
   output logic                               avs_waitrequest_out,
   output logic                               ext_irq_out,
   output logic                               wake_out
);
   import eip_pkg::*;

   localparam logic [ID_W-1:0] SRC_LAST = ID_W'(NUM_SRC);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   eip_state_t        s;
   eip_state_t        next_s;
   logic [LEAVES-1:0] req_vec;
   eip_cand_t         node [1:2*LEAVES-1];

   // ----------------------------------------------------------------
   // Gateways
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < LEAVES; gi = gi + 1) begin : g_gw
         if (gi >= 1 && gi <= NUM_SRC) begin : g_on
            eip_gateway u_gw (
               .clk_sys_in (clk_sys_in),
               .srst_in    (srst_in),
               .src_in     (src_req_in[gi]),
               .pol_in     (s.gw_pol[gi]),
               .edge_in    (s.gw_type[gi]),
               .clr_in     (s.gw_clr[gi]),
               .req_out    (req_vec[gi])
            );
         end else begin : g_off
            assign req_vec[gi] = 1'b0;
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Evaluation tree
   // ----------------------------------------------------------------
   genvar li;
   generate
      for (li = 0; li < LEAVES; li = li + 1) begin : g_leaf
         if (li >= 1 && li <= NUM_SRC) begin : g_on
            assign node[LEAVES+li].prio = (req_vec[li] && s.en[li]) ?
                                          s.prio[li] : PRIO_NONE;
         end else begin : g_off
            assign node[LEAVES+li].prio = PRIO_NONE;
         end
         assign node[LEAVES+li].id = ID_W'(li);
      end
   endgenerate

   genvar ni;
   generate
      for (ni = 1; ni < LEAVES; ni = ni + 1) begin : g_node
         eip_cmp u_cmp (
            .a_in    (node[2*ni]),
            .b_in    (node[2*ni+1]),
            .win_out (node[ni])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [PRIO_W-1:0] inv;
      logic [PRIO_W-1:0] level;
      logic [2:0]        region;
      logic [7:0]        idx;
      logic              src_ok;
      logic [DATA_W-1:0] rd_val;
      logic [DATA_W-1:0] mask;
      logic [DATA_W-1:0] wval;
      logic              commit;
      inv    = {PRIO_W{s.rev}};
      level  = (s.thresh > s.curpri) ? s.thresh : s.curpri;
      region = avs_address_in[12:10];
      idx    = avs_address_in[9:2];
      src_ok = (idx != ID_NONE) && (idx <= SRC_LAST);
      rd_val = RD_ZERO;
      mask   = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
      commit = avs_write_in && !s.waitreq;
      wval   = RD_ZERO;
      next_s        = s;
      next_s.gw_clr = '0;

      // Read value of the addressed register
      case (region)
         REGION_CTRL: begin
            case (idx)
               OFS_CONFIG:  rd_val[BIT_REVERSE] = s.rev;
               OFS_THRESH:  rd_val[PRIO_W-1:0] = s.thresh ^ inv;
               OFS_CURPRI:  rd_val[PRIO_W-1:0] = s.curpri ^ inv;
               OFS_HPTR: begin
                  rd_val[HPTR_ID_LSB +: ID_W]     = s.cap_id;
                  rd_val[HPTR_BASE_LSB +: BASE_W] = s.vt_base;
               end
               OFS_CAPPRI:  rd_val[PRIO_W-1:0] = s.cap_prio ^ inv;
               OFS_VTBASE:  rd_val[HPTR_BASE_LSB +: BASE_W] = s.vt_base;
               OFS_STATUS: begin
                  rd_val[BIT_ST_IRQ]  = s.ext_irq;
                  rd_val[BIT_ST_WAKE] = s.wake;
               end
               default:     rd_val = RD_ZERO;
            endcase
         end
         REGION_PRIO: begin
            if (src_ok) begin
               rd_val[PRIO_W-1:0] = s.prio[idx] ^ inv;
            end
         end
         REGION_EN: begin
            if (src_ok) begin
               rd_val[BIT_ENABLE] = s.en[idx];
            end
         end
         REGION_GCFG: begin
            if (src_ok) begin
               rd_val[BIT_POLARITY] = s.gw_pol[idx];
               rd_val[BIT_TYPE]     = s.gw_type[idx];
            end
         end
         REGION_PEND: begin
            if (idx[7:3] == 5'h00) begin
               rd_val = req_vec[DATA_W*idx[2:0] +: DATA_W];
            end
         end
         default: rd_val = RD_ZERO;
      endcase

      wval = (rd_val & ~mask) | (avs_writedata_in & mask);

      // Bus handshake: one wait cycle, then the answer
      if ((avs_read_in || avs_write_in) && s.waitreq) begin
         next_s.waitreq = 1'b0;
         if (avs_read_in) begin
            next_s.rdata = rd_val;
         end
      end else begin
         next_s.waitreq = 1'b1;
      end

      // Register writes at the accepting edge
      if (commit) begin
         case (region)
            REGION_CTRL: begin
               case (idx)
                  OFS_CONFIG:  next_s.rev = wval[BIT_REVERSE];
                  OFS_THRESH:  next_s.thresh = wval[PRIO_W-1:0] ^ inv;
                  OFS_CURPRI:  next_s.curpri = wval[PRIO_W-1:0] ^ inv;
                  OFS_CAPTURE: begin
                     next_s.cap_id   = s.win.id;
                     next_s.cap_prio = s.win.prio;
                  end
                  OFS_VTBASE:  next_s.vt_base = wval[HPTR_BASE_LSB +: BASE_W];
                  default:     next_s.rev = s.rev;
               endcase
            end
            REGION_PRIO: begin
               if (src_ok) begin
                  next_s.prio[idx] = wval[PRIO_W-1:0] ^ inv;
               end
            end
            REGION_EN: begin
               if (src_ok) begin
                  next_s.en[idx] = wval[BIT_ENABLE];
               end
            end
            REGION_GCFG: begin
               if (src_ok) begin
                  next_s.gw_pol[idx]  = wval[BIT_POLARITY];
                  next_s.gw_type[idx] = wval[BIT_TYPE];
               end
            end
            REGION_GCLR: begin
               if (src_ok) begin
                  next_s.gw_clr[idx] = 1'b1;
               end
            end
            default: next_s.rev = s.rev;
         endcase
      end

      // Continuous evaluation, staged by two registers: winner, then request and wake
      next_s.win     = node[1];
      next_s.ext_irq = (s.win.prio > level);
      next_s.wake    = (s.win.prio == PRIO_TOP);
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         s         <= '0;
         s.waitreq <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign avs_readdata_out    = s.rdata;
   assign avs_waitrequest_out = s.waitreq;
   assign ext_irq_out         = s.ext_irq;
   assign wake_out            = s.wake;

endmodule
`default_nettype wire

// [inc/eip_pkg.sv]
// Package of constants and carrier types for the external interrupt prioritizer
`default_nettype none
package eip_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int unsigned MAX_SRC  = 255;
   localparam int unsigned LEAVES   = 256;
   localparam int unsigned PRIO_W   = 4;
   localparam int unsigned ID_W     = 8;
   localparam int unsigned BASE_W   = 22;
   localparam int unsigned ADDR_W   = 13;
   localparam int unsigned DATA_W   = 32;

   localparam logic [PRIO_W-1:0] PRIO_NONE = 4'h0;
   localparam logic [PRIO_W-1:0] PRIO_TOP  = 4'hF;
   localparam logic [ID_W-1:0]   ID_NONE   = 8'h00;

   // ----------------------------------------------------------------
   // Register map (address region codes and word offsets)
   // ----------------------------------------------------------------
   localparam logic [2:0]  REGION_CTRL = 3'h0;
   localparam logic [2:0]  REGION_PRIO = 3'h1;
   localparam logic [2:0]  REGION_EN   = 3'h2;
   localparam logic [2:0]  REGION_GCFG = 3'h3;
   localparam logic [2:0]  REGION_GCLR = 3'h4;
   localparam logic [2:0]  REGION_PEND = 3'h5;

   localparam logic [7:0]  OFS_CONFIG  = 8'h00;
   localparam logic [7:0]  OFS_THRESH  = 8'h01;
   localparam logic [7:0]  OFS_CURPRI  = 8'h02;
   localparam logic [7:0]  OFS_CAPTURE = 8'h03;
   localparam logic [7:0]  OFS_HPTR    = 8'h04;
   localparam logic [7:0]  OFS_CAPPRI  = 8'h05;
   localparam logic [7:0]  OFS_VTBASE  = 8'h06;
   localparam logic [7:0]  OFS_STATUS  = 8'h07;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned BIT_REVERSE  = 0;
   localparam int unsigned BIT_ENABLE   = 0;
   localparam int unsigned BIT_POLARITY = 0;
   localparam int unsigned BIT_TYPE     = 1;
   localparam int unsigned BIT_ST_IRQ   = 0;
   localparam int unsigned BIT_ST_WAKE  = 1;
   localparam int unsigned HPTR_ID_LSB  = 2;
   localparam int unsigned HPTR_BASE_LSB = 10;

   localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [PRIO_W-1:0] prio;
      logic [ID_W-1:0]   id;
   } eip_cand_t;

   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
      logic pend;
   } eip_gw_state_t;

   typedef struct packed {
      logic                         rev;
      logic [PRIO_W-1:0]            thresh;
      logic [PRIO_W-1:0]            curpri;
      logic [ID_W-1:0]              cap_id;
      logic [PRIO_W-1:0]            cap_prio;
      logic [BASE_W-1:0]            vt_base;
      logic [LEAVES-1:0][PRIO_W-1:0] prio;
      logic [LEAVES-1:0]            en;
      logic [LEAVES-1:0]            gw_pol;
      logic [LEAVES-1:0]            gw_type;
      logic [LEAVES-1:0]            gw_clr;
      eip_cand_t                    win;
      logic                         ext_irq;
      logic                         wake;
      logic [DATA_W-1:0]            rdata;
      logic                         waitreq;
   } eip_state_t;

endpackage
`default_nettype wire

// [verification/eip_far_model.sv]
// Far-side model: interrupt source pins and hart acceptance
`timescale 1ns/1ps
`default_nettype none
module eip_far_model #(
   parameter int unsigned NUM_SRC = 8
) (
   input  wire logic             clk_sys_in,
   input  wire logic             srst_in,
   input  wire logic [NUM_SRC:1] want_in,
   input  wire logic             ext_irq_in,
   output logic      [NUM_SRC:1] src_out,
   output logic                  taken_out
);
   logic hold;
   logic mie;
   always_ff @(posedge clk_sys_in) begin
      taken_out <= 1'b0;
      hold      <= 1'b1;
      if (srst_in) begin
         src_out <= want_in;
         mie     <= 1'b1;
      end else begin
         if (want_in != src_out && hold) begin
            src_out <= want_in;
            hold    <= 1'b0;
         end
         if (ext_irq_in && mie) begin
            mie       <= 1'b0;
            taken_out <= 1'b1;
         end else if (!ext_irq_in) begin
            mie <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// [verification/eip_top_bench.sv]
// Self-checking bench of the prioritizer against an integer model
`timescale 1ns/1ps
`default_nettype none
module eip_top_bench;
   import eip_pkg::*;
   localparam int N = 8;
   localparam logic [31:0] VT = 32'h1234_5C00;
   logic        clk_sys_in = 1'b0;
   logic        srst_in    = 1'b1;
   logic [12:0] addr       = 13'h0000;
   logic        rd         = 1'b0;
   logic        wr         = 1'b0;
   logic [31:0] wdata      = 32'h0000_0000;
   logic [31:0] rdata;
   logic        waitreq;
   logic        irq;
   logic        wake;
   logic [N:1]  want       = 8'h00;
   logic [N:1]  src;
   logic [N:1]  typ        = 8'h44;
   logic [N:1]  pol        = 8'h50;
   logic [N:1]  pend       = 8'h00;
   logic [N:1]  en         = 8'h00;
   logic [3:0]  be         = 4'hF;
   logic [3:0]  pr [0:N];
   logic [3:0]  thi        = 4'h0;
   logic [3:0]  cui        = 4'h0;
   logic [3:0]  rm         = 4'h0;
   logic [3:0]  cap_p      = 4'h0;
   int          cap_id     = 0;
   logic [31:0] seed       = 32'h0000_F6D7;
   int          err_total  = 0;
   int          num_checks = 0;
   always #2 clk_sys_in = ~clk_sys_in;
   eip_far_model #(.NUM_SRC(N)) u_far (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
      .want_in(want), .ext_irq_in(irq), .src_out(src), .taken_out());
   eip_top #(.NUM_SRC(N)) u_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
      .src_req_in(src), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
      .avs_waitrequest_out(waitreq), .ext_irq_out(irq), .wake_out(wake));
   // ----------------------------------------------------------------
   // Model
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic req(int i);
      return typ[i] ? pend[i] : (want[i] ^ pol[i]);
   endfunction
   function automatic int win_id();
      int b = 0;
      for (int i = 1; i <= N; i++) begin
         if (req(i) && en[i] && pr[i] > pr[b]) begin
            b = i;
         end
      end
      return b;
   endfunction
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic tally_and_finish();
      if (err_total == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check_word(logic [31:0] got, logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: read %h, model %h", $time, got, exp);
      end
   endtask
   task automatic check_pin(logic got, logic exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: output %b, model %b", $time, got, exp);
      end
   endtask
   task automatic bus(logic w, logic [12:0] a, logic [31:0] d, output logic [31:0] q);
      int n = 0;
      @(posedge clk_sys_in);
      addr  <= a;
      wdata <= d;
      wr    <= w;
      rd    <= !w;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (waitreq !== 1'b0 && n < 50);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (waitreq !== 1'b0) begin
         err_total++;
         $display("unexpected at %0t: bus hang", $time);
         tally_and_finish();
      end
   endtask
   task automatic wr_reg(logic [12:0] a, logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(logic [12:0] a, logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check_word(q, exp);
   endtask
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] r;
      logic [31:0] pw;
      int          id;
      logic        xi;
      for (int i = 0; i <= N; i++) begin
         pr[i] = 4'h0;
      end
      repeat (5) @(posedge clk_sys_in);
      srst_in <= 1'b0;
      wr_reg(13'h000, 32'h0);
      for (int i = 1; i <= N; i++) begin
         wr_reg(13'hC00 + 13'(4 * i), {30'h0, typ[i], pol[i]});
         wr_reg(13'h1000 + 13'(4 * i), 32'h0);
      end
      wr_reg(13'h018, VT);
      wr_reg(13'h004, 32'h0);
      be <= 4'hE;
      wr_reg(13'h004, 32'h0000_000F);
      be <= 4'hF;
      rd_chk(13'h004, 32'h0);
      rd_chk(13'h018, {VT[31:10], 10'h000});
      wr_reg(13'h008, 32'h0);
      rd_chk(13'h1C00, 32'h0);
      rd_chk(13'h00C, 32'h0);
      for (int k = 0; k < 24; k++) begin
         r = rnd();
         rm = k[2] ? 4'hF : 4'h0;
         wr_reg(13'h000, {31'h0, k[2]});
         for (int i = 1; i <= N; i++) begin
            if (typ[i] && (r[i] ^ pol[i]) && !(want[i] ^ pol[i])) begin
               pend[i] = 1'b1;
            end
         end
         want <= r[N:1];
         id = int'(r[12:9]) % N + 1;
         pr[id] = r[16:13];
         wr_reg(13'h400 + 13'(4 * id), {28'h0, pr[id] ^ rm});
         thi = {1'b0, r[19:17]};
         cui = {1'b0, r[22:20]};
         wr_reg(13'h004, {28'h0, thi ^ rm});
         wr_reg(13'h008, {28'h0, cui ^ rm});
         for (int i = 1; i <= N; i++) begin
            en[i] = r[23 + i % 8] | r[i];
            wr_reg(13'h800 + 13'(4 * i), {31'h0, en[i]});
         end
         repeat (12) @(posedge clk_sys_in);
         pw = 32'h0;
         for (int i = 1; i <= N; i++) begin
            pw[i] = req(i);
         end
         xi = pr[win_id()] > thi && pr[win_id()] > cui;
         check_pin(irq, xi);
         check_pin(wake, pr[win_id()] == 4'hF);
         rd_chk(13'h01C, {30'h0, pr[win_id()] == 4'hF, xi});
         rd_chk(13'h1400, pw);
         rd_chk(13'h010, {VT[31:10], 8'(cap_id), 2'b00});
         rd_chk(13'h014, {28'h0, cap_p ^ rm});
         wr_reg(13'h00C, r);
         cap_id = win_id();
         cap_p = pr[cap_id];
         rd_chk(13'h010, {VT[31:10], 8'(cap_id), 2'b00});
         rd_chk(13'h014, {28'h0, cap_p ^ rm});
         rd_chk(13'h004, {28'h0, thi ^ rm});
         rd_chk(13'h008, {28'h0, cui ^ rm});
         rd_chk(13'h400 + 13'(4 * id), {28'h0, pr[id] ^ rm});
         rd_chk(13'h800 + 13'(4 * id), {31'h0, en[id]});
         rd_chk(13'hC00 + 13'(4 * id), {30'h0, typ[id], pol[id]});
         rd_chk(13'h000, {31'h0, k[2]});
         if (r[31]) begin
            wr_reg(13'h100C, 32'h0);
            wr_reg(13'h101C, 32'h0);
            pend = 8'h00;
         end
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire

// [verification/eip_top_props.sv]
// Checker of bus timing and readback relations of the prioritizer
`timescale 1ns/1ps
`default_nettype none
module eip_top_props #(
   parameter int unsigned NUM_SRC = 255
) (
   input wire logic             clk_sys_in,
   input wire logic             srst_in,
   input wire logic [NUM_SRC:1] src_req_in,
   input wire logic [12:0]      avs_address_in,
   input wire logic             avs_read_in,
   input wire logic             avs_write_in,
   input wire logic [31:0]      avs_writedata_in,
   input wire logic [3:0]       avs_byteenable_in,
   input wire logic [31:0]      avs_readdata_out,
   input wire logic             avs_waitrequest_out,
   input wire logic             ext_irq_out,
   input wire logic             wake_out
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (srst_in);
   // ----------------------------------------------------------------
   // Bus steps
   // ----------------------------------------------------------------
   sequence bus_req;
      (avs_read_in || avs_write_in) && avs_waitrequest_out;
   endsequence
   sequence rd_at(logic [12:0] a);
      avs_read_in && avs_waitrequest_out && avs_address_in == a;
   endsequence
   sequence quiet_run;
      (!avs_write_in && $stable(src_req_in)) [*8];
   endsequence
   wait_one_a: assert property (bus_req |=> !avs_waitrequest_out)
      else $error("access not answered after one wait cycle");
   wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("waitrequest low for more than one cycle");
   no_spurious_a: assert property (!avs_read_in && !avs_write_in && avs_waitrequest_out
      |=> avs_waitrequest_out) else $error("answer without request");
   rdata_hold_a: assert property (!(avs_read_in && avs_waitrequest_out)
      |=> $stable(avs_readdata_out)) else $error("read data moved without read");
   unmapped_zero_a: assert property (avs_read_in && avs_waitrequest_out
      && (avs_address_in[12:10] > 3'h4 && avs_address_in[12:10] != 3'h5
      || avs_address_in[12:10] == 3'h4 || avs_address_in == 13'h00C)
      |=> avs_readdata_out == 32'h0000_0000) else $error("write-only place read nonzero");
   hptr_low_a: assert property (rd_at(13'h010) |=> avs_readdata_out[1:0] == 2'b00)
      else $error("pointer low bits nonzero");
   pend_zero_a: assert property (rd_at(13'h1400) |=> !avs_readdata_out[0])
      else $error("pending bit of id zero set");
   status_pins_a: assert property (rd_at(13'h01C) |=>
      avs_readdata_out[1:0] == {$past(wake_out), $past(ext_irq_out)})
      else $error("status differs from outputs");
   ext_quiet_a: assert property (quiet_run |=> $stable(ext_irq_out) && $stable(wake_out))
      else $error("outputs moved with inputs quiet");
   reset_quiet_a: assert property ($fell(srst_in) |-> !ext_irq_out && !wake_out
      && avs_waitrequest_out) else $error("outputs active after reset");
endmodule
bind eip_top eip_top_props #(.NUM_SRC(NUM_SRC)) u_props (
   .clk_sys_in(clk_sys_in), .srst_in(srst_in), .src_req_in(src_req_in),
   .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .ext_irq_out(ext_irq_out), .wake_out(wake_out));
`default_nettype wire
